// ### design/fte_pkg.sv
`default_nettype none
package fte_pkg;
	// ==========================================================
	// clocking
	localparam int REF_CLK_MHZ = 250;
	localparam int LINE_RATE_MBPS = 125;
	localparam int CLKS_PER_BIT = REF_CLK_MHZ / LINE_RATE_MBPS;
	localparam int DIV_W = 2;
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CLKS_PER_BIT - 1);
	localparam logic [DIV_W-1:0] DIV_PRE = DIV_W'(CLKS_PER_BIT - 2);
	localparam logic [DIV_W-1:0] DIV_RST = 2'h0;

	// ==========================================================
	// code groups
	localparam int CG_W = 5;
	localparam logic [2:0] CG_LAST = 3'h4;
	localparam logic [2:0] BIT_RST = 3'h0;
	localparam logic [CG_W-1:0] CG_I = 5'h1f;
	localparam logic [CG_W-1:0] CG_J = 5'h18;
	localparam logic [CG_W-1:0] CG_K = 5'h11;
	localparam logic [CG_W-1:0] CG_T = 5'h0d;
	localparam logic [CG_W-1:0] CG_R = 5'h07;
	localparam logic [CG_W-1:0] CG_H = 5'h04;
	localparam logic [3:0] NIB_SSD = 4'h5;
	localparam logic [3:0] NIB_CTRL = 4'h0;

	// ==========================================================
	// scrambler and line
	localparam int LFSR_W = 11;
	localparam int TAP_A = 10;
	localparam int TAP_B = 8;
	localparam logic [5:0] SEED_HI = 6'h3f;
	localparam logic [1:0] MLT_ZERO_A = 2'h0;
	localparam logic [1:0] MLT_POS = 2'h1;
	localparam logic [1:0] MLT_NEG = 2'h3;

	typedef enum logic [2:0] {
		FTE_IDLE = 3'b000,
		FTE_J = 3'b001,
		FTE_K = 3'b010,
		FTE_DATA = 3'b011,
		FTE_T = 3'b100,
		FTE_R = 3'b101
	} fte_state_t;

	function automatic logic [CG_W-1:0] fte_encode(input logic [3:0] nib);
		logic [CG_W-1:0] cg;
		cg = CG_I;
		case (nib)
			4'h0: cg = 5'h1e;
			4'h1: cg = 5'h09;
			4'h2: cg = 5'h14;
			4'h3: cg = 5'h15;
			4'h4: cg = 5'h0a;
			4'h5: cg = 5'h0b;
			4'h6: cg = 5'h0e;
			4'h7: cg = 5'h0f;
			4'h8: cg = 5'h12;
			4'h9: cg = 5'h13;
			4'ha: cg = 5'h16;
			4'hb: cg = 5'h17;
			4'hc: cg = 5'h1a;
			4'hd: cg = 5'h1b;
			4'he: cg = 5'h1c;
			4'hf: cg = 5'h1d;
			default: cg = CG_I;
		endcase
		return cg;
	endfunction

	function automatic logic [LFSR_W-1:0] fte_seed(input logic [4:0] straps);
		return {SEED_HI, straps};
	endfunction
endpackage
`default_nettype wire

// ### design/fte_cg_codec.sv
`timescale 1ns/1ps
`default_nettype none
module fte_cg_codec (
	// code group in
	input wire logic [fte_pkg::CG_W-1:0] cg,
	input wire logic data_field,
	// decoded out
	output logic [3:0] nibble,
	output logic invalid
);
	import fte_pkg::*;

	logic ctrl;

	always_comb begin
		nibble = NIB_CTRL;
		ctrl = 1'b0;
		invalid = 1'b0;
		case (cg)
			CG_J, CG_K: begin
				nibble = NIB_SSD;
				ctrl = 1'b1;
			end
			CG_I, CG_T, CG_R: begin
				nibble = NIB_CTRL;
				ctrl = 1'b1;
			end
			CG_H: ctrl = 1'b1;
			5'h00, 5'h01, 5'h02, 5'h03,
			5'h05, 5'h06, 5'h08, 5'h0c: invalid = 1'b1;
			default: begin
				for (int n = 0; n < 16; n++) begin
					if (fte_encode(4'(n)) == cg) begin
						nibble = 4'(n);
					end
				end
			end
		endcase
		if (ctrl && data_field) begin
			invalid = 1'b1;
		end
	end
endmodule // fte_cg_codec
`default_nettype wire

// ### design/fte_tx_encoder.sv
`timescale 1ns/1ps
`default_nettype none
module fte_tx_encoder (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// controller nibble interface
	input wire logic tx_en,
	input wire logic tx_er,
	input wire logic [3:0] txd,
	output logic nibble_take_r,
	// configuration
	input wire logic [4:0] phy_address_straps,
	input wire logic conv_bypass,
	// line streams
	output logic line_pos_r,
	output logic line_neg_r,
	output logic nrzi_r,
	// transmit monitor
	output logic tx_active_r,
	output logic [3:0] mon_nibble_r,
	output logic mon_err_r
);
	import fte_pkg::*;

	// ==========================================================
	// framing
	fte_state_t state_r, state_nxt;
	logic [DIV_W-1:0] div_r, div_nxt;
	logic [2:0] bit_cnt_r, bit_cnt_nxt;
	logic [CG_W-1:0] shift_r, shift_nxt;
	logic take_nxt, active_nxt;
	logic [3:0] mon_nib_nxt, dec_nibble;
	logic mon_err_nxt, dec_invalid, data_field;
	logic bit_en, cg_load;

	assign bit_en = (div_r == DIV_LAST);
	assign cg_load = bit_en && (bit_cnt_r == CG_LAST);
	assign data_field = (state_r == FTE_DATA) && tx_en;

	fte_cg_codec u_codec (
		.cg(shift_nxt),
		.data_field(data_field),
		.nibble(dec_nibble),
		.invalid(dec_invalid)
	);

	always_comb begin
		state_nxt = state_r;
		div_nxt = bit_en ? DIV_RST : div_r + 1'b1;
		bit_cnt_nxt = bit_cnt_r;
		shift_nxt = shift_r;
		take_nxt = (div_r == DIV_PRE) && (bit_cnt_r == CG_LAST);
		active_nxt = tx_active_r;
		mon_nib_nxt = mon_nibble_r;
		mon_err_nxt = mon_err_r;
		if (bit_en) begin
			bit_cnt_nxt = cg_load ? BIT_RST : bit_cnt_r + 1'b1;
			shift_nxt = {1'b0, shift_r[CG_W-1:1]};
		end
		if (cg_load) begin
			unique case (state_r)
				FTE_IDLE: begin
					if (tx_en) begin
						shift_nxt = CG_J;
						state_nxt = FTE_J;
					end else begin
						shift_nxt = CG_I;
					end
				end
				FTE_J: begin
					shift_nxt = CG_K;
					state_nxt = FTE_DATA;
				end
				FTE_DATA: begin
					if (!tx_en) begin
						shift_nxt = CG_T;
						state_nxt = FTE_T;
					end else if (tx_er) begin
						shift_nxt = CG_H;
					end else begin
						shift_nxt = fte_encode(txd);
					end
				end
				FTE_T: begin
					shift_nxt = CG_R;
					state_nxt = FTE_R;
				end
				FTE_R: begin
					shift_nxt = CG_I;
					state_nxt = FTE_IDLE;
				end
				default: begin
					shift_nxt = CG_I;
					state_nxt = FTE_IDLE;
				end
			endcase
			active_nxt = (state_nxt != FTE_IDLE);
			mon_nib_nxt = dec_nibble;
			mon_err_nxt = dec_invalid;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_r <= FTE_IDLE;
			div_r <= DIV_RST;
			bit_cnt_r <= BIT_RST;
			shift_r <= CG_I;
			nibble_take_r <= 1'b0;
			tx_active_r <= 1'b0;
			mon_nibble_r <= NIB_CTRL;
			mon_err_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			div_r <= div_nxt;
			bit_cnt_r <= bit_cnt_nxt;
			shift_r <= shift_nxt;
			nibble_take_r <= take_nxt;
			tx_active_r <= active_nxt;
			mon_nibble_r <= mon_nib_nxt;
			mon_err_r <= mon_err_nxt;
		end
	end

	// ==========================================================
	// scrambler, NRZI and MLT-3
	logic [LFSR_W-1:0] lfsr_r, lfsr_nxt;
	logic [1:0] phase_r, phase_nxt;
	logic nrzi_nxt, pos_nxt, neg_nxt, fb, scr_bit, step;
	logic last_neg_r, last_neg_nxt;

	assign fb = lfsr_r[TAP_A] ^ lfsr_r[TAP_B];
	assign scr_bit = shift_r[0] ^ fb;
	assign step = conv_bypass ? shift_r[0] : scr_bit;

	always_comb begin
		lfsr_nxt = lfsr_r;
		nrzi_nxt = nrzi_r;
		phase_nxt = phase_r;
		if (bit_en) begin
			lfsr_nxt = {lfsr_r[LFSR_W-2:0], fb};
			if (!conv_bypass) begin
				nrzi_nxt = nrzi_r ^ scr_bit;
			end
			if (step) begin
				phase_nxt = phase_r + 1'b1;
			end
		end
		pos_nxt = (phase_nxt == MLT_POS);
		neg_nxt = (phase_nxt == MLT_NEG);
		// last nonzero line level, for the alternation check
		last_neg_nxt = last_neg_r;
		if (line_pos_r) begin
			last_neg_nxt = 1'b0;
		end else if (line_neg_r) begin
			last_neg_nxt = 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			lfsr_r <= fte_seed(phy_address_straps);
			nrzi_r <= 1'b0;
			phase_r <= MLT_ZERO_A;
			line_pos_r <= 1'b0;
			line_neg_r <= 1'b0;
			last_neg_r <= 1'b1;
		end else begin
			lfsr_r <= lfsr_nxt;
			nrzi_r <= nrzi_nxt;
			phase_r <= phase_nxt;
			line_pos_r <= pos_nxt;
			line_neg_r <= neg_nxt;
			last_neg_r <= last_neg_nxt;
		end
	end

	// ==========================================================
	// checks
	code_map_a: assert property (@(posedge ref_clk) disable iff (rst)
		cg_load && state_r == FTE_DATA && tx_en && !tx_er
		|=> shift_r == fte_encode($past(txd)))
		else $error("data nibble not mapped to its code group");
	start_pair_a: assert property (@(posedge ref_clk) disable iff (rst)
		cg_load && state_r == FTE_IDLE && tx_en
		|=> shift_r == CG_J ##10 shift_r == CG_K)
		else $error("start delimiter not J then K");
	end_pair_a: assert property (@(posedge ref_clk) disable iff (rst)
		cg_load && state_r == FTE_DATA && !tx_en
		|=> shift_r == CG_T ##10 shift_r == CG_R ##10 shift_r == CG_I)
		else $error("end delimiter not T then R");
	idle_fill_a: assert property (@(posedge ref_clk) disable iff (rst)
		cg_load && state_r == FTE_IDLE && !tx_en |=> shift_r == CG_I)
		else $error("idle not sent between frames");
	halt_code_a: assert property (@(posedge ref_clk) disable iff (rst)
		cg_load && state_r == FTE_DATA && tx_en && tx_er
		|=> shift_r == CG_H && mon_err_r)
		else $error("error nibble not sent as halt");
	nrzi_toggle_a: assert property (@(posedge ref_clk) disable iff (rst)
		bit_en && !conv_bypass |=> nrzi_r == ($past(nrzi_r) ^ $past(scr_bit)))
		else $error("nrzi does not follow scrambled bit");
	three_level_a: assert property (@(posedge ref_clk) disable iff (rst)
		!(line_pos_r && line_neg_r))
		else $error("line streams overlap");
	pulse_alt_a: assert property (@(posedge ref_clk) disable iff (rst)
		($rose(line_pos_r) |-> last_neg_r)
		and ($rose(line_neg_r) |-> !last_neg_r))
		else $error("line one events do not alternate");
	bit_rate_a: assert property (@(posedge ref_clk) disable iff (rst)
		bit_en |=> !bit_en ##1 bit_en)
		else $error("bit enable not every second clock");
	lfsr_live_a: assert property (@(posedge ref_clk) disable iff (rst)
		lfsr_r != '0)
		else $error("scrambler register locked at zero");
	ctrl_decode_a: assert property (@(posedge ref_clk) disable iff (rst)
		cg_load && state_r == FTE_J |=> mon_nibble_r == NIB_SSD)
		else $error("K group not decoded to 0101");
endmodule // fte_tx_encoder
`default_nettype wire

// ### bench/fte_mac_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// mac model: one nibble per take, txd keeps moving when idle
module fte_mac_model (
	// clock and take
	input wire logic ref_clk,
	input wire logic nibble_take_r,
	// frame request, go toggles
	input wire logic go,
	input wire logic [15:0] len,
	input wire logic [15:0] err_at,
	// mii outputs
	output logic tx_en,
	output logic tx_er,
	output logic [3:0] txd
);
	logic [15:0] idx = 16'hffff;
	logic took = 1'b0;
	logic seen = 1'b0;
	always @(posedge ref_clk) took <= nibble_take_r;
	always @(negedge ref_clk) begin
		seen <= go;
		if (go != seen) begin
			idx <= 16'h0;
		end else if (took && idx != 16'hffff) begin
			idx <= idx + 16'h1;
		end
	end
	assign tx_en = idx < len;
	assign tx_er = tx_en && idx == err_at;
	assign txd = idx[3:0] + 4'h3;
endmodule // fte_mac_model
`default_nettype wire

// ### bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// transmit encoder bench
module tb_top;
	import fte_pkg::*;
	logic ref_clk, rst, tx_en, tx_er, take, bypass, go, pos, neg, nrzi;
	logic act, merr;
	logic nz = 1'b0;
	logic ph = 1'b0;
	logic [3:0] txd, mnib;
	logic [4:0] straps;
	logic [15:0] len, err_at;
	logic [1:0] lv = 2'h0;
	int err_cnt = 0;
	int take_cnt = 0;
	logic [39:0] va, vb;
	logic bitq[$];
	logic nzq[$];
	int num_errors = 0;
	int checked = 0;
	logic [4:0] enc [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b,
		5'h0e, 5'h0f, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c,
		5'h1d};
	fte_tx_encoder u_fte_tx_encoder (.ref_clk(ref_clk), .rst(rst),
		.tx_en(tx_en), .tx_er(tx_er), .txd(txd), .nibble_take_r(take),
		.phy_address_straps(straps), .conv_bypass(bypass),
		.line_pos_r(pos), .line_neg_r(neg), .nrzi_r(nrzi),
		.tx_active_r(act), .mon_nibble_r(mnib), .mon_err_r(merr));
	fte_mac_model u_fte_mac_model (.ref_clk(ref_clk), .nibble_take_r(take),
		.go(go), .len(len), .err_at(err_at), .tx_en(tx_en),
		.tx_er(tx_er), .txd(txd));
	// ==========================================================
	// line monitor: one sample per bit, change flags
	always @(posedge ref_clk) begin
		ph <= ~ph;
		if (merr === 1'b1) err_cnt <= err_cnt + 1;
		if (take === 1'b1) take_cnt <= take_cnt + 1;
		if (ph) begin
			lv <= {pos, neg};
			nz <= nrzi;
			bitq.push_back({pos, neg} !== lv);
			nzq.push_back(nrzi !== nz);
		end
	end
	task automatic cmp(input logic [4:0] got, input logic [4:0] exp,
		input string m);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %0t %s", $time, m);
		end
	endtask
	task automatic give_verdict();
		$display("checked %0d num_errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic do_reset(input logic [4:0] s);
		@(negedge ref_clk);
		rst = 1'b1;
		straps = s;
		repeat (8) @(negedge ref_clk);
		rst = 1'b0;
		cmp({1'b0, pos, neg, nrzi, act}, 5'h0, "reset state");
	endtask
	// ==========================================================
	// bypassed frame: whole group stream found on the line
	task automatic run_frame(input int n, input int e);
		logic [4:0] g[$];
		logic b[$];
		logic hit, ok;
		int base, e0;
		g = '{CG_I, CG_J, CG_K};
		for (int i = 2; i < n; i++) begin
			g.push_back(i == e ? CG_H : enc[4'(i + 3)]);
		end
		g.push_back(CG_T);
		g.push_back(CG_R);
		g.push_back(CG_I);
		foreach (g[k]) for (int j = 0; j < 5; j++) b.push_back(g[k][j]);
		@(negedge ref_clk);
		bypass = 1'b1;
		repeat (20) @(negedge ref_clk);
		// align to a take so the idle group ahead of J is fully seen
		@(posedge take);
		@(negedge ref_clk);
		base = bitq.size();
		e0 = err_cnt;
		len <= 16'(n);
		err_at <= 16'(e);
		go <= ~go;
		@(posedge act);
		@(negedge ref_clk);
		cmp({1'b0, mnib}, 5'h5, "start nibble");
		repeat (n * 10 + 80) @(negedge ref_clk);
		cmp({1'b0, mnib}, 5'h0, "idle nibble");
		cmp({4'h0, err_cnt != e0}, {4'h0, e < n}, "error flag");
		hit = 1'b0;
		for (int p = base; p + b.size() <= bitq.size(); p++) begin
			ok = 1'b1;
			foreach (b[k]) if (bitq[p + k] !== b[k]) ok = 1'b0;
			hit |= ok;
		end
		cmp({4'h0, hit}, 5'h1, "group stream");
	endtask
	// ==========================================================
	// scrambled idle: mlt steps follow nrzi toggles
	task automatic scramble(input logic [4:0] s, output logic [39:0] v);
		int d, base, t0, grp;
		bypass = 1'b0;
		do_reset(s);
		t0 = take_cnt;
		// one take per serialised group in a window of 100 clocks
		grp = 100 / (CG_W * CLKS_PER_BIT);
		repeat (100) @(negedge ref_clk);
		cmp(5'(take_cnt - t0), 5'(grp), "take rate");
		base = nzq.size();
		repeat (84) @(negedge ref_clk);
		d = 0;
		for (int k = 0; k < 40; k++) begin
			v[k] = nzq[base + k];
			d += int'(nzq[base + k] !== bitq[base + k]);
		end
		cmp(5'(d), 5'h0, "mlt vs nrzi");
		cmp({4'h0, &v}, 5'h0, "idle not scrambled");
	endtask
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	initial begin
		repeat (3000) @(posedge ref_clk);
		num_errors++;
		$display("ERROR %0t timeout", $time);
		give_verdict();
	end
	initial begin
		rst = 1'b1;
		bypass = 1'b1;
		straps = 5'h0a;
		go = 1'b0;
		len = 16'h0;
		err_at = 16'h0;
		do_reset(5'h0a);
		run_frame(18, 18);
		run_frame(6, 3);
		scramble(5'h0a, va);
		scramble(5'h15, vb);
		cmp({4'h0, va === vb}, 5'h0, "seed from straps");
		give_verdict();
	end
endmodule // tb_top
`default_nettype wire
